// ### design/pwg_ctrl.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - the pad-seven fifth-subperiod byte is pad seven's fifth subperiod in 8-bit mode and the upper byte of pad six's in 16-bit mode.
// - the pad-six fifth-subperiod byte is pad six's fifth subperiod in 8-bit mode and its lower byte in 16-bit mode.
// - writing a duration register sets the period count, pad seven's byte being the upper byte in 16-bit mode.
// - a duration count of zero makes the waveform run without end.
// - reading a duration register returns the periods still left, with the same byte split.
// - each of the low four enable bits switches generation on or off for its pad pair.
// - with a width bit clear both pads of the pair are driven with 8-bit counters.
// - with a width bit set the odd pad is released and the even pad runs 16-bit counters.
// - chain bits link waveforms so that one ends exactly where the next starts.
// - an even chain bit starts pad b after pad b+1 in 8-bit mode or after pad b+2 in 16-bit mode.
// - an odd chain bit starts pad b after pad b+1 in 8-bit mode and is ignored in 16-bit mode.
// - chain bit 6 starts pad six when pad seven ends in 8-bit mode and is ignored in 16-bit mode.
// - two dividers each divide the clock by two to the power d+1, d from one nibble.
// - a pad reset bit stops that pad's waveform and clears its counters until it is cleared.
module pwg_ctrl
  import pwg_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic padSixOut,
  output logic padSixOeN,
  output logic padSevenOut,
  output logic padSevenOeN,
  output logic padSixDone,
  output logic padSevenDone
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] subHi [NUM_SUBPERIODS];
  logic [7:0] subLo [NUM_SUBPERIODS];
  logic [7:0] waveform_enable_and_width;
  logic [6:0] waveform_chain_links;
  logic [7:0] waveform_clock_dividers;
  logic [7:0] waveform_divider_select;
  logic [7:0] waveform_pad_reset;
  logic [15:0] remain [2];
  logic [7:0] lowSnapshot;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic ack;
  logic [13:0] regIdx;
  logic wrStrobe;
  logic rdStrobe;
  logic [7:0] wrByte;
  logic wrN6;
  logic wrN7;
  logic wide;
  logic [31:0] next_readdata;

  assign regIdx = avs_address[15:2];
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  // writes land only at the edge where waitrequest is seen low
  assign wrStrobe = avs_write && ack && avs_byteenable[0];
  assign rdStrobe = avs_read && !ack;
  assign wrByte = avs_writedata[7:0];
  assign wide = waveform_enable_and_width[CFG_WIDE_BIT];
  assign wrN6 = wrStrobe && (regIdx == IDX_PERIOD_COUNT_PAD6_LOWER);
  assign wrN7 = wrStrobe && (regIdx == IDX_PERIOD_COUNT_PAD7_OR_UPPER);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < NUM_SUBPERIODS; k++) begin
        subHi[k] <= RST_BYTE;
        subLo[k] <= RST_BYTE;
      end
    end else if (wrStrobe) begin
      for (int k = 0; k < NUM_SUBPERIODS - 1; k++) begin
        if (regIdx == IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k)) begin
          subHi[k] <= wrByte;
        end
        if (regIdx == IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k + 1)) begin
          subLo[k] <= wrByte;
        end
      end
      if (regIdx == IDX_FIFTH_SUB_PAD7_OR_UPPER) begin
        subHi[NUM_SUBPERIODS-1] <= wrByte;
      end
      if (regIdx == IDX_FIFTH_SUB_PAD6_LOWER) begin
        subLo[NUM_SUBPERIODS-1] <= wrByte;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waveform_enable_and_width <= RST_BYTE;
      waveform_chain_links <= RST_CHAIN;
      waveform_clock_dividers <= RST_BYTE;
      waveform_divider_select <= RST_BYTE;
      waveform_pad_reset <= RST_BYTE;
    end else if (wrStrobe) begin
      case (regIdx)
        IDX_WAVEFORM_ENABLE_AND_WIDTH: waveform_enable_and_width <= wrByte;
        IDX_WAVEFORM_CHAIN_LINKS: waveform_chain_links <= wrByte[6:0];
        IDX_WAVEFORM_CLOCK_DIVIDERS: waveform_clock_dividers <= wrByte;
        IDX_WAVEFORM_DIVIDER_SELECT: waveform_divider_select <= wrByte;
        IDX_WAVEFORM_PAD_RESET: waveform_pad_reset <= wrByte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // coherent 16-bit duration read
  // ----------------------------------------------------------------
  // upper-byte read freezes the lower byte for the read that follows;
  // taken at the edge that loads the upper byte, so no decrement
  // can fall between the two halves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lowSnapshot <= RST_BYTE;
    end else if (rdStrobe && wide &&
                 regIdx == IDX_PERIOD_COUNT_PAD7_OR_UPPER) begin
      lowSnapshot <= remain[0][7:0];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    next_readdata = 32'h0000_0000;
    for (int k = 0; k < NUM_SUBPERIODS; k++) begin
      if (regIdx == IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k)) begin
        next_readdata[7:0] = subHi[k];
      end
      if (regIdx == IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k + 1)) begin
        next_readdata[7:0] = subLo[k];
      end
    end
    case (regIdx)
      IDX_PERIOD_COUNT_PAD7_OR_UPPER: begin
        next_readdata[7:0] = wide ? remain[0][15:8] : remain[1][7:0];
      end
      IDX_PERIOD_COUNT_PAD6_LOWER: begin
        next_readdata[7:0] = wide ? lowSnapshot : remain[0][7:0];
      end
      IDX_WAVEFORM_ENABLE_AND_WIDTH: begin
        next_readdata[7:0] = waveform_enable_and_width;
      end
      IDX_WAVEFORM_CHAIN_LINKS: begin
        next_readdata[6:0] = waveform_chain_links;
      end
      IDX_WAVEFORM_CLOCK_DIVIDERS: begin
        next_readdata[7:0] = waveform_clock_dividers;
      end
      IDX_WAVEFORM_DIVIDER_SELECT: begin
        next_readdata[7:0] = waveform_divider_select;
      end
      IDX_WAVEFORM_PAD_RESET: begin
        next_readdata[7:0] = waveform_pad_reset;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------
  logic tickDiv1;
  logic tickDiv2;

  pwg_clock_divider u_div1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .divExp(waveform_clock_dividers[DIV1_LSB +: 4]),
    .tick(tickDiv1)
  );

  pwg_clock_divider u_div2 (
    .clk_sys(clk_sys),
    .reset(reset),
    .divExp(waveform_clock_dividers[DIV2_LSB +: 4]),
    .tick(tickDiv2)
  );

  // ----------------------------------------------------------------
  // waveform lanes: lane 0 is pad six, lane 1 is pad seven
  // ----------------------------------------------------------------
  logic [1:0] laneLevel;
  logic [1:0] laneActive;
  logic [1:0] laneDonePulse;
  logic [1:0] laneDone;

  for (genvar L = 0; L < 2; L++) begin : g_lane
    pwg_state_t state;
    logic [15:0] tickCnt;
    logic [2:0] subIdx;
    logic [15:0] subVal;
    logic tick;
    logic padRst;
    logic boundary;
    logic periodEnd;
    logic chainHold;
    logic startNow;

    // odd pad is released in 16-bit mode
    assign laneActive[L] = waveform_enable_and_width[CFG_ENABLE_PAIR_BIT] &&
                           !(L == 1 && wide);
    assign padRst = waveform_pad_reset[PAD_SIX_BIT + L];
    assign tick = waveform_divider_select[PAD_SIX_BIT + L] ?
                  tickDiv2 : tickDiv1;

    always_comb begin
      subVal = 16'h0000;
      for (int k = 0; k < NUM_SUBPERIODS; k++) begin
        if (subIdx == 3'(k)) begin
          if (L == 1) begin
            subVal = {8'h00, subHi[k]};
          end else if (wide) begin
            subVal = {subHi[k], subLo[k]};
          end else begin
            subVal = {8'h00, subLo[k]};
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // subperiod timing
    // ----------------------------------------------------------------
    // zero-length subperiods last one tick
    assign boundary = (state == PWG_RUN) && tick &&
                      (tickCnt + 16'h0001 >= subVal);
    assign periodEnd = boundary && (subIdx == 3'(NUM_SUBPERIODS - 1));
    // chain bit 6 has no effect in 16-bit mode
    assign chainHold = (L == 0) && !wide &&
                       waveform_chain_links[CHAIN_SIX_AFTER_SEVEN_BIT];
    // chained start follows the finishing edge of pad seven directly
    assign startNow = chainHold ? laneDonePulse[1] : 1'b1;
    // a remaining count of 1 at period end is the last period
    assign laneDonePulse[L] = periodEnd && (remain[L] == 16'h0001);
    assign laneDone[L] = (state == PWG_DONE);

    // ----------------------------------------------------------------
    // lane sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
      if (reset || padRst || !laneActive[L]) begin
        state <= PWG_IDLE;
      end else begin
        case (state)
          PWG_IDLE: state <= chainHold ? PWG_WAIT : PWG_RUN;
          PWG_WAIT: begin
            if (startNow) begin
              state <= PWG_RUN;
            end
          end
          PWG_RUN: begin
            if (laneDonePulse[L]) begin
              state <= PWG_DONE;
            end
          end
          PWG_DONE: ;
          default: state <= PWG_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (reset || padRst || state != PWG_RUN) begin
        tickCnt <= 16'h0000;
        subIdx <= 3'h0;
      end else if (boundary) begin
        tickCnt <= 16'h0000;
        subIdx <= periodEnd ? 3'h0 : subIdx + 3'h1;
      end else if (tick) begin
        tickCnt <= tickCnt + 16'h0001;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (reset || padRst || !laneActive[L]) begin
        laneLevel[L] <= 1'b0;
      end else if (boundary) begin
        laneLevel[L] <= !laneLevel[L];
      end
    end

    // ----------------------------------------------------------------
    // period count
    // ----------------------------------------------------------------
    // remaining period count; bus write wins over a decrement
    // pad reset leaves it alone, so a restarted pad resumes its count
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        remain[L] <= RST_COUNT;
      end else if (L == 0 && wrN6) begin
        remain[L] <= wide ? {remain[L][15:8], wrByte} :
                            {8'h00, wrByte};
      end else if (L == 0 && wrN7 && wide) begin
        remain[L] <= {wrByte, remain[L][7:0]};
      end else if (L == 1 && wrN7 && !wide) begin
        remain[L] <= {8'h00, wrByte};
      end else if (periodEnd && remain[L] != 16'h0000) begin
        remain[L] <= remain[L] - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  assign padSixOut = laneLevel[0];
  assign padSevenOut = laneLevel[1];
  assign padSixOeN = !laneActive[0];
  assign padSevenOeN = !laneActive[1];
  // pad six finishing is what chains on the lower pads wait for
  assign padSixDone = laneDone[0];
  assign padSevenDone = laneDone[1];

endmodule : pwg_ctrl

// ### design/pwg_pkg.sv
package pwg_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_FIRST_SUB_PAD7_OR_UPPER = 14'h10A4;
  localparam logic [13:0] IDX_FIFTH_SUB_PAD7_OR_UPPER = 14'h10AC;
  localparam logic [13:0] IDX_FIFTH_SUB_PAD6_LOWER = 14'h10AD;
  localparam logic [13:0] IDX_PERIOD_COUNT_PAD7_OR_UPPER = 14'h10AE;
  localparam logic [13:0] IDX_PERIOD_COUNT_PAD6_LOWER = 14'h10AF;
  localparam logic [13:0] IDX_WAVEFORM_ENABLE_AND_WIDTH = 14'h10B0;
  localparam logic [13:0] IDX_WAVEFORM_CHAIN_LINKS = 14'h10B1;
  localparam logic [13:0] IDX_WAVEFORM_CLOCK_DIVIDERS = 14'h10B2;
  localparam logic [13:0] IDX_WAVEFORM_DIVIDER_SELECT = 14'h10B3;
  localparam logic [13:0] IDX_WAVEFORM_PAD_RESET = 14'h10B5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE_PAIR_BIT = 3;
  localparam int CFG_WIDE_BIT = 7;
  localparam int CHAIN_SIX_AFTER_SEVEN_BIT = 6;
  localparam int PAD_SIX_BIT = 6;
  localparam int DIV1_LSB = 0;
  localparam int DIV2_LSB = 4;
  localparam int NUM_SUBPERIODS = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_CHAIN = 7'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef enum logic [1:0] {
    PWG_IDLE,
    PWG_WAIT,
    PWG_RUN,
    PWG_DONE
  } pwg_state_t;

endpackage : pwg_pkg

// ### design/pwg_clock_divider.sv
`timescale 1ns/1ps
module pwg_clock_divider
  import pwg_pkg::*;
#(
  parameter int CNT_W = 17
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] divExp,
  output logic tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;

  // division by two to the power d+1
  // five-bit shift amount so d of 15 does not wrap to a shift of zero
  assign limit = (CNT_W'(1) << ({1'b0, divExp} + 5'h01)) - CNT_W'(1);

  // compare with >= so a smaller divisor takes effect at once
  assign tick = (count >= limit);

  always_ff @(posedge clk_sys) begin
    if (reset || tick) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

endmodule : pwg_clock_divider

// ### sim/pwg_ctrl_properties.sv
`timescale 1ns/1ps
module pwg_ctrl_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic padSixOut,
  input wire logic padSixOeN,
  input wire logic padSevenOut,
  input wire logic padSevenOeN,
  input wire logic padSixDone,
  input wire logic padSevenDone
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait on first request cycle");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait lasted over one cycle");
  AST_READ_UPPER_ZERO: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper read bits set");

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  AST_SEVEN_NEEDS_PAIR: assert property (!padSevenOeN |-> !padSixOeN)
    else $error("pad seven driven without its pair");
  AST_SIX_OFF_LOW: assert property (padSixOeN [*2]
    |-> !padSixOut && !padSixDone) else $error("pad six active while off");
  AST_SEVEN_OFF_LOW: assert property (padSevenOeN [*2]
    |-> !padSevenOut && !padSevenDone) else $error("pad seven active off");
  AST_SIX_DONE_HOLD: assert property (padSixDone && $past(padSixDone)
    |-> $stable(padSixOut)) else $error("pad six moved after done");
  AST_SEVEN_DONE_HOLD: assert property (padSevenDone
    && $past(padSevenDone) |-> $stable(padSevenOut))
    else $error("pad seven moved after done");
endmodule : pwg_ctrl_checker

bind pwg_ctrl pwg_ctrl_checker i_pwg_ctrl_checker (
  .clk_sys(clk_sys),
  .reset(reset),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .padSixOut(padSixOut),
  .padSixOeN(padSixOeN),
  .padSevenOut(padSevenOut),
  .padSevenOeN(padSevenOeN),
  .padSixDone(padSixDone),
  .padSevenDone(padSevenDone)
);

// ### sim/pwg_ctrl_tb.sv
`timescale 1ns/1ps
module pwg_ctrl_tb;
  import pwg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic padSixOut, padSixOeN, padSevenOut, padSevenOeN;
  logic padSixDone, padSevenDone;
  logic [31:0] rv;
  int fails = 0;
  int totalChecks = 0;
  int tg, gap;

  always #5 clk_sys = ~clk_sys;

  pwg_ctrl i_pwg_ctrl (
    .clk_sys(clk_sys),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .padSixOut(padSixOut),
    .padSixOeN(padSixOeN),
    .padSevenOut(padSevenOut),
    .padSevenOeN(padSevenOeN),
    .padSixDone(padSixDone),
    .padSevenDone(padSevenDone)
  );

  task print_verdict;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // bus access, entered just after a clock edge
  // ----------------------------------------------------------------
  task bus(input logic isWr, input logic [13:0] idx, input logic [7:0] d,
           input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= isWr;
    avs_read <= !isWr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest && n < 100);
    rv = avs_readdata;
    if (n >= 100) begin
      fails++;
      print_verdict();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // idle edge so the next request is a fresh one
    @(posedge clk_sys);
  endtask : bus

  task wr(input logic [13:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask : wr

  task rd(input logic [13:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hF);
    chk(rv, {24'h000000, e});
  endtask : rd

  // toggle count and widest gap between toggles of pad six
  task watch(input int n);
    logic prev;
    int last;
    tg = 0;
    gap = 0;
    last = 0;
    prev = padSixOut;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (padSixOut !== prev) begin
        if (tg > 0 && i - last > gap) gap = i - last;
        tg++;
        last = i;
        prev = padSixOut;
      end
    end
  endtask : watch

  initial begin
    #300000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int k = 0; k < 6; k++) begin
      rd(IDX_FIFTH_SUB_PAD7_OR_UPPER + 14'(k), 8'h00);
    end
    wr(14'h10B7, 8'hFF);
    rd(14'h10B7, 8'h00);
    bus(1'b1, IDX_WAVEFORM_CHAIN_LINKS, 8'hFF, 4'h0);
    rd(IDX_WAVEFORM_CHAIN_LINKS, 8'h00);
    wr(IDX_WAVEFORM_CHAIN_LINKS, 8'hFF);
    rd(IDX_WAVEFORM_CHAIN_LINKS, 8'h7F);
    wr(IDX_WAVEFORM_CHAIN_LINKS, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k), 8'h00);
      wr(IDX_FIRST_SUB_PAD7_OR_UPPER + 14'(2 * k + 1), 8'h01);
    end
    wr(IDX_FIFTH_SUB_PAD7_OR_UPPER, 8'h01);
    wr(IDX_FIFTH_SUB_PAD6_LOWER, 8'h03);
    rd(IDX_FIFTH_SUB_PAD6_LOWER, 8'h03);
    // ----------------------------------------------------------------
    // 8-bit single period, then slower divider
    // ----------------------------------------------------------------
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h01);
    rd(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h01);
    // enable last: the watch must begin before the first boundary
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h08);
    watch(60);
    chk(tg, 5);
    chk(gap, 6);
    chk(padSixDone, 1'b1);
    chk(padSevenOeN, 1'b0);
    chk(padSevenDone, 1'b0);
    rd(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h00);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h00);
    chk(padSixOeN, 1'b1);
    wr(IDX_WAVEFORM_CLOCK_DIVIDERS, 8'h01);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h08);
    watch(80);
    chk(gap, 12);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h00);
    wr(IDX_WAVEFORM_CLOCK_DIVIDERS, 8'h10);
    // ----------------------------------------------------------------
    // 16-bit mode
    // ----------------------------------------------------------------
    // one 16-bit period, count loaded while the pair is off
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h80);
    wr(IDX_PERIOD_COUNT_PAD7_OR_UPPER, 8'h00);
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h01);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h88);
    watch(600);
    chk(tg, 5);
    chk(gap, 518);
    chk(padSevenOeN, 1'b1);
    chk(padSixDone, 1'b1);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h80);
    wr(IDX_PERIOD_COUNT_PAD7_OR_UPPER, 8'h01);
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h02);
    rd(IDX_PERIOD_COUNT_PAD7_OR_UPPER, 8'h01);
    rd(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h02);
    // ----------------------------------------------------------------
    // endless run and pad reset
    // ----------------------------------------------------------------
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h00);
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h00);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h08);
    watch(200);
    chk(padSixDone, 1'b0);
    chk(32'(tg > 40), 1);
    wr(IDX_WAVEFORM_PAD_RESET, 8'h40);
    watch(10);
    chk(padSixOut, 1'b0);
    watch(50);
    chk(tg, 0);
    wr(IDX_WAVEFORM_PAD_RESET, 8'h00);
    watch(50);
    chk(32'(tg > 0), 1);
    // ----------------------------------------------------------------
    // chaining six after seven
    // ----------------------------------------------------------------
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h00);
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h01);
    wr(IDX_PERIOD_COUNT_PAD7_OR_UPPER, 8'h01);
    wr(IDX_WAVEFORM_CHAIN_LINKS, 8'h40);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h08);
    watch(6);
    chk(tg, 0);
    watch(60);
    chk(tg, 5);
    chk(padSevenDone, 1'b1);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h00);
    wr(IDX_PERIOD_COUNT_PAD6_LOWER, 8'h00);
    wr(IDX_WAVEFORM_ENABLE_AND_WIDTH, 8'h88);
    watch(6);
    chk(32'(tg > 0), 1);
    print_verdict();
  end
endmodule : pwg_ctrl_tb
